// ---- hw/dpdio_top.sv ----
// dual port digital io with stream triggers, frequency counter and pulse generator
//
// The implementer's own choices: the placing of the registers and the APB slave port.
`timescale 1ns/1ps
module dpdio_top
(
    // clock and reset
    input  wire logic        mclk_in,
    input  wire logic        nrst_in,
    // apb slave
    input  wire logic        psel_in,
    input  wire logic        penable_in,
    input  wire logic        pwrite_in,
    input  wire logic [7:0]  paddr_in,
    input  wire logic [31:0] pwdata_in,
    output logic      [31:0] prdata_out,
    output logic             pready_out,
    output logic             pslverr_out,
    // digital ports
    input  wire logic [15:0] porta_in,
    output logic      [15:0] porta_out,
    output logic      [15:0] porta_oe_out,
    input  wire logic [15:0] portb_in,
    output logic      [15:0] portb_out,
    output logic      [15:0] portb_oe_out,
    // triggers
    input  wire logic        trigger_input_first_in,
    input  wire logic        trigger_input_second_in,
    // board controls
    output logic             data_valid_out,
    output logic             term_a_out,
    output logic             term_b_out,
    output logic             level_5v_out,
    output logic             sysclk_en_out,
    output logic             irq_out
);
    import dpdio_pkg::*;
    ////////////////////////////////////////////////////////////////////////////
    logic [CTRL_W-1:0] ctrl_r;
    logic [14:0]       trig_r;
    logic [15:0]       douta_r, doutb_r, pmask_r, pat_prev_r;
    logic [IRQ_W-1:0]  istat_r, imask_r;
    logic [17:0]       src_prev_r;
    logic              sample_ok_r;
    logic [31:0]       gper_r [NCH], ghi_r [NCH], mper_r [NCH], mhi_r [NCH];
    logic [NCH-1:0]    mdone, pulse;
    dpdio_state_e      state_r, state_nxt;

    // bus decode: a write lands only at the completing access edge
    wire        acc     = psel_in & penable_in & pready_out;
    wire        wr      = acc & pwrite_in;
    wire        setup   = psel_in & ~penable_in;
    wire        stream  = ctrl_r[CB_STREAM];
    wire        fin     = ctrl_r[CB_FIN];
    wire        fout    = ctrl_r[CB_FOUT];
    wire        chan_hit = paddr_in >= OFS_GEN && paddr_in < OFS_MEAS + 8'h20;
    wire [1:0]  chan    = paddr_in[4:3];
    wire        is_gen  = paddr_in < OFS_MEAS;

    ////////////////////////////////////////////////////////////////////////////
    // trigger sources: port A bits, then the two dedicated inputs
    wire [17:0] srcs = {trigger_input_second_in, trigger_input_first_in, porta_in};

    function automatic logic hit(input logic [17:0] now, input logic [17:0] was,
                                 input logic [4:0] sel, input logic [1:0] edg);
        logic n;
        logic p;
        n = (sel <= SRC_TRIG2) ? now[sel] : 1'b0;
        p = (sel <= SRC_TRIG2) ? was[sel] : 1'b0;
        case (edg)
            EDGE_RISE: hit = n & ~p;
            EDGE_FALL: hit = ~n & p;
            EDGE_ANY:  hit = n ^ p;
            default:   hit = 1'b0;
        endcase
    endfunction

    // triggers act only in stream mode; single mode is software driven
    wire start_ev = stream & hit(srcs, src_prev_r, trig_r[TB_START_SRC+:5],
                                 trig_r[TB_START_EDG+:2]);
    wire stop_ev  = stream & hit(srcs, src_prev_r, trig_r[TB_STOP_SRC+:5],
                                 trig_r[TB_STOP_EDG+:2]);
    wire sw_go    = wr && paddr_in == OFS_STRM && pwdata_in[0];
    wire sw_halt  = wr && paddr_in == OFS_STRM && pwdata_in[1];
    wire no_start = trig_r[TB_START_EDG+:2] == EDGE_NONE;

    // stream sequencer: software arms, trigger or software starts, trigger or software stops
    always_comb
    begin
        state_nxt = state_r;
        case (state_r)
            ST_IDLE:  if (sw_go && stream) state_nxt = no_start ? ST_RUN : ST_ARMED;
            ST_ARMED: if (start_ev) state_nxt = ST_RUN;
            ST_RUN:   if (stop_ev) state_nxt = ST_IDLE;
            default:  state_nxt = ST_IDLE;
        endcase
        if (sw_halt || !stream)
            state_nxt = ST_IDLE;
    end

    wire running = state_r == ST_RUN;

    ////////////////////////////////////////////////////////////////////////////
    // pattern change on the monitored port A bits; upper bits lost in counter mode
    wire [15:0] din_a   = fin ? {12'h000, porta_in[3:0]} : porta_in;
    wire        pat_chg = |((din_a ^ pat_prev_r) & pmask_r);
    wire [IRQ_W-1:0] ev = {|mdone, state_r == ST_RUN && state_nxt == ST_IDLE,
                           state_r != ST_RUN && state_nxt == ST_RUN, pat_chg};
    wire [IRQ_W-1:0] w1c = (wr && paddr_in == OFS_ISTAT) ? pwdata_in[IRQ_W-1:0]
                                                         : {IRQ_W{1'b0}};

    ////////////////////////////////////////////////////////////////////////////
    // pin drive: frequency modes override, then stream, then software direction
    wire [15:0] a_oe_nxt = (stream | fin) ? 16'h0000 : {16{ctrl_r[CB_DIR_A]}};
    wire [15:0] b_oe_nxt = (stream | fout) ? 16'hffff : {16{ctrl_r[CB_DIR_B]}};
    wire [15:0] b_nxt    = fout ? {12'h000, pulse} : doutb_r;

    // read mux
    logic [31:0] rdata;
    logic        rerr;
    always_comb
    begin
        rdata = 32'h0000_0000;
        rerr  = 1'b0;
        if (paddr_in == OFS_CTRL)
            rdata = {23'h00_0000, ctrl_r};
        else if (paddr_in == OFS_TRIG)
            rdata = {17'h0_0000, trig_r};
        else if (paddr_in == OFS_DOUT_A)
            rdata = {16'h0000, douta_r};
        else if (paddr_in == OFS_DOUT_B)
            rdata = {16'h0000, doutb_r};
        else if (paddr_in == OFS_DIN_A)
            rdata = {16'h0000, din_a};
        else if (paddr_in == OFS_DIN_B)
            rdata = {16'h0000, fout ? 16'h0000 : portb_in};
        else if (paddr_in == OFS_ISTAT)
            rdata = {28'h000_0000, istat_r};
        else if (paddr_in == OFS_IMASK)
            rdata = {28'h000_0000, imask_r};
        else if (paddr_in == OFS_PMASK)
            rdata = {16'h0000, pmask_r};
        else if (paddr_in == OFS_STAT)
            rdata = {29'h0000_0000, sample_ok_r, state_r};
        else if (paddr_in == OFS_STRM)
            rdata = 32'h0000_0000;
        else if (chan_hit && is_gen)
            rdata = paddr_in[2] ? ghi_r[chan] : gper_r[chan];
        else if (chan_hit)
            rdata = paddr_in[2] ? mhi_r[chan] : mper_r[chan];
        else
            rerr = 1'b1;
    end

    ////////////////////////////////////////////////////////////////////////////
    // apb answer: one wait-free access phase, data captured during setup
    always_ff @(posedge mclk_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            prdata_out  <= 32'h0000_0000;
            pready_out  <= 1'b0;
            pslverr_out <= 1'b0;
        end
        else
        begin
            prdata_out  <= setup ? rdata : prdata_out;
            pready_out  <= setup;
            pslverr_out <= setup & rerr;
        end
    end

    // control registers; reset leaves every port an input
    always_ff @(posedge mclk_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            ctrl_r  <= CTRL_RST;
            trig_r  <= TRIG_RST;
            douta_r <= 16'h0000;
            doutb_r <= 16'h0000;
            imask_r <= {IRQ_W{1'b0}};
            pmask_r <= 16'h0000;
        end
        else if (wr)
        begin
            if (paddr_in == OFS_CTRL)
                ctrl_r <= pwdata_in[CTRL_W-1:0];
            if (paddr_in == OFS_TRIG && state_r == ST_IDLE)
                trig_r <= pwdata_in[14:0];
            if (paddr_in == OFS_DOUT_A)
                douta_r <= pwdata_in[15:0];
            if (paddr_in == OFS_DOUT_B)
                doutb_r <= pwdata_in[15:0];
            if (paddr_in == OFS_IMASK)
                imask_r <= pwdata_in[IRQ_W-1:0];
            if (paddr_in == OFS_PMASK)
                pmask_r <= pwdata_in[15:0];
        end
    end

    // state, history and sticky status; a new event beats its clear
    always_ff @(posedge mclk_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            state_r     <= ST_IDLE;
            src_prev_r  <= 18'h0_0000;
            pat_prev_r  <= 16'h0000;
            istat_r     <= {IRQ_W{1'b0}};
            sample_ok_r <= 1'b0;
        end
        else
        begin
            state_r     <= state_nxt;
            src_prev_r  <= srcs;
            pat_prev_r  <= din_a;
            istat_r     <= (istat_r & ~w1c) | ev;
            // a sample is valid once written during a run
            sample_ok_r <= running & (sample_ok_r | (wr && paddr_in == OFS_DOUT_B));
        end
    end

    // registered pins
    always_ff @(posedge mclk_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            porta_out      <= 16'h0000;
            porta_oe_out   <= 16'h0000;
            portb_out      <= 16'h0000;
            portb_oe_out   <= 16'h0000;
            data_valid_out <= 1'b0;
            term_a_out     <= 1'b0;
            term_b_out     <= 1'b0;
            level_5v_out   <= 1'b0;
            sysclk_en_out  <= 1'b0;
            irq_out        <= 1'b0;
        end
        else
        begin
            porta_out      <= douta_r;
            porta_oe_out   <= a_oe_nxt;
            portb_out      <= b_nxt;
            portb_oe_out   <= b_oe_nxt;
            data_valid_out <= stream & sample_ok_r & running;
            term_a_out     <= ctrl_r[CB_TERM_A];
            term_b_out     <= ctrl_r[CB_TERM_B];
            level_5v_out   <= ctrl_r[CB_LVL5V];
            sysclk_en_out  <= ctrl_r[CB_CLKO];
            irq_out        <= |((istat_r | ev) & imask_r);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // per channel counter and generator; one clock is one tick, so inputs
    // faster than half the clock rate alias
    genvar g;
    generate
        for (g = 0; g < NCH; g++)
        begin : g_ch
            logic [31:0] mcnt_r, mh_r, gcnt_r;
            logic        seen_r, prev_r, out_r;
            wire         rise = porta_in[g] & ~prev_r;
            wire         fall = ~porta_in[g] & prev_r;
            wire         gwr  = wr && chan_hit && is_gen && chan == 2'(g);
            wire         gend = gcnt_r + 32'h0000_0001 >= gper_r[g];
            assign mdone[g] = fin & rise & seen_r;
            assign pulse[g] = out_r;

            // measurement, rise to rise, high time latched at the fall
            always_ff @(posedge mclk_in or negedge nrst_in)
            begin
                if (!nrst_in)
                begin
                    mcnt_r  <= 32'h0000_0000;
                    mh_r    <= 32'h0000_0000;
                    seen_r  <= 1'b0;
                    prev_r  <= 1'b0;
                    mper_r[g] <= 32'h0000_0000;
                    mhi_r[g]  <= 32'h0000_0000;
                end
                else
                begin
                    prev_r <= porta_in[g];
                    if (!fin)
                        seen_r <= 1'b0;
                    else if (rise)
                    begin
                        seen_r <= 1'b1;
                        mcnt_r <= 32'h0000_0001;
                        if (seen_r)
                        begin
                            mper_r[g] <= mcnt_r;
                            mhi_r[g]  <= mh_r;
                        end
                    end
                    else
                    begin
                        mcnt_r <= mcnt_r + 32'h0000_0001;
                        if (fall)
                            mh_r <= mcnt_r;
                    end
                end
            end

            // generator: high for the programmed ticks, then low to period end
            always_ff @(posedge mclk_in or negedge nrst_in)
            begin
                if (!nrst_in)
                begin
                    gcnt_r   <= 32'h0000_0000;
                    out_r    <= 1'b0;
                    gper_r[g] <= GEN_RST;
                    ghi_r[g]  <= GEN_RST;
                end
                else
                begin
                    if (gwr && !paddr_in[2])
                        gper_r[g] <= pwdata_in;
                    if (gwr && paddr_in[2])
                        ghi_r[g] <= pwdata_in;
                    gcnt_r <= (!fout || gend) ? 32'h0000_0000 : gcnt_r + 32'h0000_0001;
                    out_r  <= fout && (gend ? ghi_r[g] != 32'h0000_0000
                                            : gcnt_r + 32'h0000_0001 < ghi_r[g]);
                end
            end
        end
    endgenerate
    ////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (!nrst_in);

    single_dir_a:   assert property (!stream && !fin |=>
                        porta_oe_out == {16{$past(ctrl_r[CB_DIR_A])}})
        else $error("port A direction not software set");
    stream_dir_a:   assert property ($past(stream) |-> porta_oe_out == 16'h0000
                        && portb_oe_out == 16'hffff)
        else $error("stream directions wrong");
    single_trigger_input_first:  assert property (!stream |=> state_r == ST_IDLE)
        else $error("trigger acted in single mode");
    rise_start_a:   assert property (state_r == ST_ARMED && !sw_halt && stream
                        && trig_r[6:5] == EDGE_RISE && start_ev |=> running)
        else $error("armed start edge missed");
    pulse_low_a:    assert property ($past(fout) |-> portb_out[15:4] == 12'h000)
        else $error("upper pulse pins not low");
    pat_irq_a:      assert property (pat_chg |=> istat_r[IB_PAT])
        else $error("pattern change not flagged");
    valid_run_a:    assert property (data_valid_out |-> $past(running))
        else $error("data valid outside a run");
    pulse_start_a:  assert property (fout && $past(fout)
                        && g_ch[1].gcnt_r == 32'h0000_0000 && ghi_r[1] > 32'h0000_0001
                        && $stable(ghi_r[1]) |-> ##1 pulse[1])
        else $error("period did not start high");
    irq_level_a:    assert property (|(istat_r & imask_r) |=> irq_out)
        else $error("masked status not on irq");
endmodule

// ---- hw/dpdio_pkg.sv ----
// constants for the dual port digital io and trigger block
package dpdio_pkg;
    // register byte offsets
    localparam logic [7:0] OFS_CTRL   = 8'h00;
    localparam logic [7:0] OFS_TRIG   = 8'h04;
    localparam logic [7:0] OFS_DOUT_A = 8'h08;
    localparam logic [7:0] OFS_DOUT_B = 8'h0c;
    localparam logic [7:0] OFS_DIN_A  = 8'h10;
    localparam logic [7:0] OFS_DIN_B  = 8'h14;
    localparam logic [7:0] OFS_ISTAT  = 8'h18;
    localparam logic [7:0] OFS_IMASK  = 8'h1c;
    localparam logic [7:0] OFS_PMASK  = 8'h20;
    localparam logic [7:0] OFS_STAT   = 8'h24;
    localparam logic [7:0] OFS_STRM   = 8'h28;
    localparam logic [7:0] OFS_GEN    = 8'h40;  // period, high: 8 bytes per channel
    localparam logic [7:0] OFS_MEAS   = 8'h60;  // period, high: 8 bytes per channel
    // ctrl fields
    localparam int CB_STREAM = 0;
    localparam int CB_FIN    = 1;
    localparam int CB_FOUT   = 2;
    localparam int CB_TERM_A = 3;
    localparam int CB_TERM_B = 4;
    localparam int CB_LVL5V  = 5;
    localparam int CB_CLKO   = 6;
    localparam int CB_DIR_A  = 7;
    localparam int CB_DIR_B  = 8;
    localparam int CTRL_W    = 9;
    localparam logic [8:0] CTRL_RST = 9'h000;
    // trig fields: start source [4:0], start edge [6:5], stop source [12:8], stop edge [14:13]
    localparam int TB_START_SRC = 0;
    localparam int TB_START_EDG = 5;
    localparam int TB_STOP_SRC  = 8;
    localparam int TB_STOP_EDG  = 13;
    localparam logic [14:0] TRIG_RST = 15'h0000;
    localparam logic [4:0] SRC_TRIG1 = 5'h10;
    localparam logic [4:0] SRC_TRIG2 = 5'h11;
    // interrupt status bits
    localparam int IB_PAT   = 0;
    localparam int IB_START = 1;
    localparam int IB_STOP  = 2;
    localparam int IB_MEAS  = 3;
    localparam int IRQ_W    = 4;
    localparam logic [31:0] GEN_RST = 32'h0000_0000;
    localparam int NCH = 4;
    typedef enum logic [1:0]
    {
        EDGE_NONE = 2'b00,
        EDGE_RISE = 2'b01,
        EDGE_FALL = 2'b10,
        EDGE_ANY  = 2'b11
    } dpdio_edge_e;
    typedef enum logic [1:0]
    {
        ST_IDLE  = 2'b00,
        ST_ARMED = 2'b01,
        ST_RUN   = 2'b10
    } dpdio_state_e;
endpackage

// ---- sim/dpdio_ext_model.sv ----
// far side model: user circuitry wired to the two digital port connectors
`timescale 1ns/1ps
module dpdio_ext_model
#(
    parameter int SQ_PER = 8,
    parameter int SQ_HI  = 3
)
(
    // clock
    input  wire logic        mclk_in,
    // levels the user circuit applies
    input  wire logic [15:0] ext_a_in,
    input  wire logic [15:0] ext_b_in,
    input  wire logic        sq_en_in,
    // device pin drivers
    input  wire logic [15:0] dut_a_in,
    input  wire logic [15:0] dut_a_oe_in,
    input  wire logic [15:0] dut_b_in,
    input  wire logic [15:0] dut_b_oe_in,
    // resolved pin levels
    output logic      [15:0] pin_a_out,
    output logic      [15:0] pin_b_out
);
    int          cnt_r;
    logic        sq_r;
    logic [15:0] src_a;

    // free running square wave on port A bit 0 for the frequency counter
    always_ff @(posedge mclk_in)
    begin
        cnt_r <= (cnt_r >= SQ_PER - 1) ? 0 : cnt_r + 1;
        sq_r  <= sq_en_in && (cnt_r < SQ_HI);
    end

    // the user circuit drives every pin the device releases, so no pin floats
    assign src_a     = {ext_a_in[15:1], sq_en_in ? sq_r : ext_a_in[0]};
    assign pin_a_out = (dut_a_oe_in & dut_a_in) | (~dut_a_oe_in & src_a);
    assign pin_b_out = (dut_b_oe_in & dut_b_in) | (~dut_b_oe_in & ext_b_in);
endmodule

// ---- sim/dpdio_top_tb_top.sv ----
// self-checking bench for the dual port digital io block
`timescale 1ns/1ps
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin bad_count++; \
    $display("ERROR t=%0t got %h exp %h", $time, (g), (e)); end end
module dpdio_top_tb_top;
    import dpdio_pkg::*;
    logic mclk_in, nrst_in, psel, penable, pwrite, pready, perr, t1, t2, sq_en;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, d;
    logic [15:0] ext_a, ext_b, pa, pb, pa_o, pa_oe, pb_o, pb_oe;
    logic dv, ta, tb, l5, ck, irq;
    int bad_count, tests_run, t0, tl, th;

    dpdio_top u_dut (.mclk_in(mclk_in), .nrst_in(nrst_in), .psel_in(psel),
        .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata),
        .prdata_out(prdata), .pready_out(pready), .pslverr_out(perr), .porta_in(pa),
        .porta_out(pa_o), .porta_oe_out(pa_oe), .portb_in(pb), .portb_out(pb_o),
        .portb_oe_out(pb_oe), .trigger_input_first_in(t1), .trigger_input_second_in(t2),
        .data_valid_out(dv), .term_a_out(ta), .term_b_out(tb), .level_5v_out(l5),
        .sysclk_en_out(ck), .irq_out(irq));
    dpdio_ext_model u_ext (.mclk_in(mclk_in), .ext_a_in(ext_a), .ext_b_in(ext_b),
        .sq_en_in(sq_en), .dut_a_in(pa_o), .dut_a_oe_in(pa_oe), .dut_b_in(pb_o),
        .dut_b_oe_in(pb_oe), .pin_a_out(pa), .pin_b_out(pb));

    ////////////////////////////////////////////////////////////////////////////////
    // one apb transfer; the request is held until pready is sampled high
    task apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
        int n;
        n = 0;
        @(posedge mclk_in);
        psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= wd;
        @(posedge mclk_in);
        penable <= 1'b1;
        do @(posedge mclk_in); while (pready !== 1'b1 && ++n < 50);
        if (pready !== 1'b1)
            bad_count++;
        d = prdata;
        psel <= 1'b0; penable <= 1'b0;
    endtask
    task wr(input logic [7:0] a, input logic [31:0] wd); apb(1'b1, a, wd); endtask
    task rd(input logic [7:0] a); apb(1'b0, a, 32'h0000_0000); endtask
    task idle(input int n); repeat (n) @(posedge mclk_in); endtask
    task stop_test;
        $display("checks %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // clock and watchdog; the whole sequence needs a few hundred cycles
    initial
    begin
        mclk_in = 1'b0;
        forever #50 mclk_in = ~mclk_in;
    end
    initial
    begin
        #2_000_000;
        bad_count++;
        stop_test;
    end

    initial
    begin
        {psel, penable, pwrite, t1, t2, sq_en, nrst_in} = '0;
        {paddr, pwdata, ext_a, ext_b} = '0;
        idle(6);
        nrst_in <= 1'b1;
        `CHK({pa_oe, pb_oe, irq, dv}, 34'h0)
        rd(OFS_CTRL); `CHK(d, 32'h0000_0000)
        rd(OFS_TRIG); `CHK(d, 32'h0000_0000)
        apb(1'b0, 8'h2c, 0); `CHK(perr, 1'b1)
        $display("reset and map test done");
        // per-port direction in single mode
        ext_a <= 16'hc3c3;
        wr(OFS_CTRL, 1 << CB_DIR_A); wr(OFS_DOUT_A, 16'h1234); idle(3);
        `CHK({pa_oe, pb_oe, pa_o}, 48'hffff_0000_1234)
        wr(OFS_CTRL, 1 << CB_DIR_B); wr(OFS_DOUT_B, 16'habcd); idle(3);
        `CHK({pa_oe, pb_oe, pb_o}, 48'h0000_ffff_abcd)
        rd(OFS_DIN_A); `CHK(d[15:0], 16'hc3c3)
        wr(OFS_CTRL, 32'h0000_0078); idle(3);
        `CHK({ck, l5, tb, ta}, 4'hf)
        $display("direction and board control test done");
        // software start is refused and triggers are ignored in single mode
        wr(OFS_CTRL, 0); wr(OFS_TRIG, {25'h0, 2'd3, SRC_TRIG1}); wr(OFS_STRM, 1);
        t1 <= 1'b1; idle(4); t1 <= 1'b0; idle(4);
        rd(OFS_STAT); `CHK(d[1:0], 2'd0)
        // rising, falling and any start edge settings on the first trigger, stop on any edge of the second
        wr(OFS_CTRL, (1 << CB_STREAM) | (1 << CB_DIR_A)); idle(3);
        `CHK({pa_oe, pb_oe}, 32'h0000_ffff)
        for (int e = 1; e < 4; e++)
        begin
            wr(OFS_TRIG, {17'h0, 2'd3, SRC_TRIG2, 1'b0, 2'(e), SRC_TRIG1});
            wr(OFS_STRM, 1); rd(OFS_STAT); `CHK(d[1:0], 2'd1)
            t1 <= 1'b1; idle(4);
            rd(OFS_STAT); `CHK(d[1:0], e[0] ? 2'd2 : 2'd1)
            t1 <= 1'b0; idle(4);
            rd(OFS_STAT); `CHK(d[1:0], 2'd2)
            t2 <= ~t2; idle(4);
            rd(OFS_STAT); `CHK(d[1:0], 2'd0)
        end
        // port A bit 3 as start source, then data valid while running
        wr(OFS_TRIG, {25'h0, 2'd1, 5'd3}); wr(OFS_STRM, 1);
        ext_a <= 16'h0008; idle(4);
        rd(OFS_STAT); `CHK(d[1:0], 2'd2)
        wr(OFS_DOUT_B, 16'h5a5a); idle(4);
        `CHK({dv, pb_o}, 17'h1_5a5a)
        wr(OFS_STRM, 2); idle(3); `CHK(dv, 1'b0)
        rd(OFS_ISTAT); `CHK(d[2:1], 2'b11)
        $display("stream trigger test done");
        // pattern change interrupt: raise, clear, mask
        wr(OFS_CTRL, 0); wr(OFS_ISTAT, 32'h0000_000f);
        wr(OFS_PMASK, 16'h0020); wr(OFS_IMASK, 1);
        ext_a <= 16'h0040; idle(4); `CHK(irq, 1'b0)
        ext_a <= 16'h0060; idle(4); `CHK(irq, 1'b1)
        rd(OFS_ISTAT); `CHK(d[0], 1'b1)
        wr(OFS_ISTAT, 1); idle(2); `CHK(irq, 1'b0)
        wr(OFS_IMASK, 0); ext_a <= 16'hff40; idle(4); `CHK(irq, 1'b0)
        rd(OFS_ISTAT); `CHK(d[0], 1'b1)
        wr(OFS_ISTAT, 1);
        $display("interrupt test done");
        // frequency counter on port A bit 0: period 8, high 3 ticks
        wr(OFS_CTRL, 1 << CB_FIN); sq_en <= 1'b1;
        for (int i = 0; i < 40 && d[IB_MEAS] !== 1'b1; i++) rd(OFS_ISTAT);
        rd(OFS_MEAS); `CHK(d, 32'h0000_0008)
        rd(OFS_MEAS + 8'h04); `CHK(d, 32'h0000_0003)
        rd(OFS_DIN_A); `CHK(d[15:4], 12'h000)
        // pulse generator channel 1: period 6, high 2 ticks
        wr(OFS_CTRL, 1 << CB_FOUT); sq_en <= 1'b0;
        wr(OFS_GEN + 8'h08, 6); wr(OFS_GEN + 8'h0c, 2);
        @(posedge pb_o[1]); t0 = $time;
        @(negedge pb_o[1]); th = $time;
        @(posedge pb_o[1]); tl = $time;
        `CHK((th - t0) / 100, 2)
        `CHK((tl - t0) / 100, 6)
        `CHK(pb_o[15:4], 12'h000)
        rd(OFS_DIN_B); `CHK(d, 32'h0000_0000)
        $display("frequency test done");
        stop_test;
    end
endmodule
